// ---- src/acp_device.sv ----
// Converter end of the control port: 3-wire and two-wire targets
//
// Operation
// - 3-wire: chip, dir=1, 5 addr, 8 data
// - 3-wire samples on rising clock edges
// - 3-wire write commits on select rising
// - Exactly sixteen edges, otherwise discarded
// - No readback over the 3-wire mode
// - Host never writes during power down
// - Power down restores all register defaults
// - Timing bit low resets timing, keeps registers
// - Two-wire target keeps running in 3-wire
// - Host changes data at falling clock only
// - Two-wire target runs up to 400 kHz
// - Target address 00100 plus address pins
// - Acknowledge only own address; 1 reads
// - Second byte register address, then data
// - Acknowledge every byte; stop ends transfer
// - Write counter increments, wraps 07 to 00
// - Acknowledged reads send next, wrap too
// - Current read sends counter byte, increments
// - No acknowledge then stop ends read
// - Random read: dummy write, repeated start
// - Controller clocks and releases acknowledge
// - Data changes only while clock low
// - Select pins choose 3-wire, two-wire, parallel
`timescale 1ns/1ps
`default_nettype none
module acp_device (
	// Clock and reset
	input  wire logic                  sys_clk_in,
	input  wire logic                  reset_in,
	// Control link
	acp_link_if.device                 link,
	// Configuration pins
	input  wire logic                  power_down_low_in,
	input  wire logic                  bus_select_in,
	input  wire logic                  parallel_serial_select_in,
	input  wire logic [1:0]            device_address_pins_in,
	// Register contents and state
	output logic [63:0]                regs_out,
	output logic                       timing_reset_out,
	output acp_pkg::acp_mode_type      mode_out
);
	// ==========================================================
	// Declarations
	typedef enum {
		T_IDLE, T_ADDR, T_ADDR_ACK, T_REG, T_REG_ACK,
		T_WDATA, T_WACK, T_RDATA, T_RACK
	} acp_twi_state_type;

	logic [7:0]            pins;            // Raw pin vector
	logic [7:0]            s1_ff;           // First sync stage only
	logic [7:0]            s2_ff;           // Stable synced pins
	logic [7:0]            s3_ff;           // Previous synced pins
	logic                  csl, csl_q;      // Chip select low
	logic                  scl, scl_q;      // Serial clock
	logic                  sda, sda_q;      // Data pin level
	logic                  pd_low;          // Power down asserted
	logic                  scl_rise, scl_fall;
	logic                  start_det, stop_det;
	logic [1:0]            cad;             // Device address pins
	logic [7:0]            reg_ff [acp_pkg::NUM_REGS]; // Register file
	acp_pkg::acp_mode_type mode_ff;         // Selected control mode
	logic                  timing_rst_ff;   // Timing reset request
	logic [15:0]           tw_sh_ff;        // 3-wire frame shifter
	logic [4:0]            tw_cnt_ff;       // Rising edges in frame
	logic                  tw_commit;       // Accepted 3-wire write
	acp_twi_state_type     st_ff;           // Two-wire target state
	logic [7:0]            sh_ff;           // Receive shifter
	logic [7:0]            tx_ff;           // Transmit shifter
	logic [3:0]            bits_ff;         // Clock rises in byte
	logic [5:0]            ptr_ff;          // Address counter
	logic                  rw_ff;           // Direction of transfer
	logic                  oe_ff;           // Device drives data pin
	logic                  dout_ff;         // Device data value
	logic                  twi_wr;          // Two-wire data byte write
	logic [7:0]            cur_byte;        // Byte at the counter

	// ==========================================================
	// Helpers
	// Next counter value, wrapping after the last register
	function automatic logic [5:0] inc_ptr(input logic [5:0] p);
		if (p >= acp_pkg::LAST_REG) begin
			return 6'h00;
		end
		return p + 6'h01;
	endfunction : inc_ptr

	// Register content at an address, zero beyond the file
	function automatic logic [7:0] reg_at(input logic [5:0] p);
		if (p > acp_pkg::LAST_REG) begin
			return 8'h00;
		end
		return reg_ff[p[2:0]];
	endfunction : reg_at

	// Software may change this address
	function automatic logic writable(input logic [5:0] p);
		return (p <= acp_pkg::LAST_REG) && (p != acp_pkg::RO_REG);
	endfunction : writable

	// ==========================================================
	// Pin synchronisers
	assign pins = {link.chip_select_low, link.control_clock,
	               link.data_level, power_down_low_in, bus_select_in,
	               parallel_serial_select_in, device_address_pins_in};

	// Two stages before use, a third for edge detection
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			s1_ff <= 8'hf0;
			s2_ff <= 8'hf0;
			s3_ff <= 8'hf0;
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	assign csl    = s2_ff[7];
	assign csl_q  = s3_ff[7];
	assign scl    = s2_ff[6];
	assign scl_q  = s3_ff[6];
	assign sda    = s2_ff[5];
	assign sda_q  = s3_ff[5];
	assign pd_low = ~s2_ff[4];
	assign cad    = s2_ff[1:0];
	assign scl_rise = scl & ~scl_q;
	assign scl_fall = ~scl & scl_q;
	// start and stop
	// Clock high on both samples, so a data change that lands with
	// the clock fall is never taken for a condition
	assign start_det = scl & scl_q & sda_q & ~sda;
	assign stop_det  = scl & scl_q & ~sda_q & sda;

	// ==========================================================
	// Mode selection
	// select pin decode
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			mode_ff <= acp_pkg::MODE_TW;
		end else if (!s2_ff[3]) begin
			mode_ff <= acp_pkg::MODE_TW;
		end else if (!s2_ff[2]) begin
			mode_ff <= acp_pkg::MODE_TWI;
		end else begin
			mode_ff <= acp_pkg::MODE_PAR;
		end
	end

	// ==========================================================
	// 3-wire receiver
	// rising edge sampling
	// Write only: nothing is ever shifted out on falling edges
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || mode_ff != acp_pkg::MODE_TW) begin
			tw_sh_ff  <= 16'h0000;
			tw_cnt_ff <= 5'h00;
		end else if (!csl && csl_q) begin
			// New frame starts counting from zero
			tw_cnt_ff <= 5'h00;
		end else if (!csl && scl_rise) begin
			tw_sh_ff <= {tw_sh_ff[14:0], sda};
			if (tw_cnt_ff != 5'(acp_pkg::TW_CNT_MAX)) begin
				tw_cnt_ff <= tw_cnt_ff + 5'h01;
			end
		end
	end

	assign tw_commit = (mode_ff == acp_pkg::MODE_TW) && csl && !csl_q &&
	                   tw_cnt_ff == 5'(acp_pkg::TW_FRAME_BITS) &&
	                   tw_sh_ff[15:14] == cad && tw_sh_ff[13] && !pd_low;

	// ==========================================================
	// Register file
	// power down defaults
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || pd_low) begin
			for (int i = 0; i < acp_pkg::NUM_REGS; i++) begin
				reg_ff[i] <= acp_pkg::REG_DEFAULTS[8*i +: 8];
			end
		end else if (tw_commit) begin
			if (writable({1'b0, tw_sh_ff[12:8]})) begin
				reg_ff[tw_sh_ff[10:8]] <= tw_sh_ff[7:0];
			end
		end else if (twi_wr && writable(ptr_ff)) begin
			reg_ff[ptr_ff[2:0]] <= sh_ff;
		end
	end

	// Flat view of the file for the converter core
	always_comb begin
		for (int i = 0; i < acp_pkg::NUM_REGS; i++) begin
			regs_out[8*i +: 8] = reg_ff[i];
		end
	end

	// timing reset only
	// Stored values are untouched, only the core timing restarts
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			timing_rst_ff <= 1'b0;
		end else begin
			timing_rst_ff <= ~reg_ff[acp_pkg::TIMING_REG][acp_pkg::TIMING_BIT];
		end
	end

	// Byte at the counter, split out so its bits can be selected
	always_comb begin
		cur_byte = reg_at(ptr_ff);
	end

	assign timing_reset_out = timing_rst_ff;
	assign mode_out         = mode_ff;

	// ==========================================================
	// Two-wire target
	// data byte write strobe
	assign twi_wr = scl_fall && st_ff == T_WDATA && bits_ff == 4'h8 &&
	                !pd_low;

	// target runs in 3-wire mode too
	// oversampled at 200 MHz, far above 400 kHz
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || mode_ff == acp_pkg::MODE_PAR || pd_low) begin
			st_ff   <= T_IDLE;
			sh_ff   <= 8'h00;
			tx_ff   <= 8'h00;
			bits_ff <= 4'h0;
			ptr_ff  <= 6'h00;
			rw_ff   <= 1'b0;
			oe_ff   <= 1'b0;
			dout_ff <= 1'b1;
		end else if (start_det) begin
			// Start or repeated start: expect an address byte
			st_ff   <= T_ADDR;
			bits_ff <= 4'h0;
			oe_ff   <= 1'b0;
		end else if (stop_det) begin
			st_ff <= T_IDLE;
			oe_ff <= 1'b0;
		end else if (scl_rise) begin
			// Every rise shifts the pin, including ack bits
			sh_ff   <= {sh_ff[6:0], sda};
			bits_ff <= bits_ff + 4'h1;
		end else if (scl_fall) begin
			// All drive changes happen while the clock is low
			unique case (st_ff)
				T_IDLE: begin
					oe_ff <= 1'b0;
				end
				T_ADDR: begin
					if (bits_ff == 4'h8) begin
						if (sh_ff[7:1] == {acp_pkg::TWI_ID, cad}) begin
							st_ff   <= T_ADDR_ACK;
							rw_ff   <= sh_ff[0];
							oe_ff   <= 1'b1;
							dout_ff <= 1'b0;
						end else begin
							st_ff <= T_IDLE;
						end
					end
				end
				T_ADDR_ACK: begin
					bits_ff <= 4'h0;
					if (rw_ff) begin
						st_ff   <= T_RDATA;
						tx_ff   <= {cur_byte[6:0], 1'b0};
						dout_ff <= cur_byte[7];
						ptr_ff  <= inc_ptr(ptr_ff);
					end else begin
						st_ff <= T_REG;
						oe_ff <= 1'b0;
					end
				end
				T_REG: begin
					if (bits_ff == 4'h8) begin
						ptr_ff  <= {1'b0, sh_ff[4:0]};
						st_ff   <= T_REG_ACK;
						oe_ff   <= 1'b1;
						dout_ff <= 1'b0;
					end
				end
				T_REG_ACK, T_WACK: begin
					st_ff   <= T_WDATA;
					bits_ff <= 4'h0;
					oe_ff   <= 1'b0;
				end
				T_WDATA: begin
					if (bits_ff == 4'h8) begin
						ptr_ff  <= inc_ptr(ptr_ff);
						st_ff   <= T_WACK;
						oe_ff   <= 1'b1;
						dout_ff <= 1'b0;
					end
				end
				T_RDATA: begin
					if (bits_ff == 4'h8) begin
						// Release for the controller's answer
						st_ff <= T_RACK;
						oe_ff <= 1'b0;
					end else begin
						dout_ff <= tx_ff[7];
						tx_ff   <= {tx_ff[6:0], 1'b0};
					end
				end
				T_RACK: begin
					bits_ff <= 4'h0;
					if (!sh_ff[0]) begin
						st_ff   <= T_RDATA;
						oe_ff   <= 1'b1;
						tx_ff   <= {cur_byte[6:0], 1'b0};
						dout_ff <= cur_byte[7];
						ptr_ff  <= inc_ptr(ptr_ff);
					end else begin
						st_ff <= T_IDLE;
					end
				end
			endcase
		end
	end

	// only the two-wire side ever drives the pin
	assign link.dev_data_out = dout_ff;
	assign link.dev_data_oe  = oe_ff;
endmodule : acp_device
`default_nettype wire

// ---- src/acp_host.sv ----
// Controller end of the control port: issues single-byte commands
`timescale 1ns/1ps
`default_nettype none
module acp_host (
	// Clock and reset
	input  wire logic                  sys_clk_in,
	input  wire logic                  reset_in,
	// Control link
	acp_link_if.host                   link,
	// Command request
	input  wire logic                  cmd_valid_in,
	input  wire acp_pkg::acp_cmd_type  cmd_kind_in,
	input  wire logic [1:0]            cmd_chip_in,
	input  wire logic [4:0]            cmd_addr_in,
	input  wire logic [7:0]            cmd_data_in,
	// Command answer
	output logic                       cmd_ready_out,
	output logic                       done_out,
	output logic                       nack_out,
	output logic [7:0]                 rd_data_out
);
	// ==========================================================
	// Declarations
	typedef enum {H_IDLE, H_START, H_BIT, H_STOP, H_TW_END} acp_host_state_type;

	acp_host_state_type   st_ff;        // Sequencer state
	acp_pkg::acp_cmd_type kind_ff;      // Command in progress
	logic [1:0]           chip_ff;      // Target chip address
	logic [4:0]           addr_ff;      // Register address
	logic [7:0]           data_ff;      // Write data
	logic [1:0]           bi_ff;        // Byte index in command
	logic [1:0]           step_ff;      // Sub-step of start or stop
	logic [3:0]           bit_ff;       // Bit index in byte or frame
	logic                 half_ff;      // Clock high half
	logic                 rd_ff;        // Current byte is read
	logic [15:0]          tx_ff;        // Transmit shifter
	logic [7:0]           rx_ff;        // Receive shifter
	logic [7:0]           div_ff;       // Half-period divider
	logic                 s1_ff, s2_ff; // Data pin synchroniser
	logic                 tick;         // Half period elapsed
	logic [8:0]           nb;           // Next byte {read, value}
	logic [8:0]           cb;           // Byte opening this step

	// ==========================================================
	// Helpers
	// two-wire command byte order
	function automatic logic [8:0] host_byte(input acp_pkg::acp_cmd_type k,
			input logic [1:0] i, input logic [1:0] c, input logic [4:0] a,
			input logic [7:0] d);
		if (i == 2'h0) begin
			return {1'b0, acp_pkg::TWI_ID, c, k == acp_pkg::CMD_CUR_READ};
		end else if (k == acp_pkg::CMD_CUR_READ || i == 2'h3) begin
			return {1'b1, 8'hff};
		end else if (i == 2'h1) begin
			return {1'b0, 3'h0, a};
		end else if (k == acp_pkg::CMD_RAND_READ) begin
			return {1'b0, acp_pkg::TWI_ID, c, 1'b1};
		end
		return {1'b0, d};
	endfunction : host_byte

	assign nb = host_byte(kind_ff, bi_ff + 2'h1, chip_ff, addr_ff, data_ff);
	assign cb = host_byte(kind_ff, bi_ff, chip_ff, addr_ff, data_ff);

	// ==========================================================
	// Clock divider and pin sync
	assign tick = (div_ff == 8'h00);

	// Link clock derived from the system clock
	always_ff @(posedge sys_clk_in) begin
		if (reset_in || st_ff == H_IDLE || tick) begin
			div_ff <= (kind_ff == acp_pkg::CMD_TW_WRITE) ?
			          8'(acp_pkg::TW_HALF - 1) : 8'(acp_pkg::TWI_HALF - 1);
		end else begin
			div_ff <= div_ff - 8'h01;
		end
	end

	// Data pin passes two flops before sampling
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
		end else begin
			s1_ff <= link.data_level;
			s2_ff <= s1_ff;
		end
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			st_ff <= H_IDLE;
			kind_ff <= acp_pkg::CMD_TWI_WRITE;
			{chip_ff, addr_ff, data_ff} <= 15'h0000;
			{bi_ff, step_ff, bit_ff, half_ff, rd_ff} <= 10'h000;
			{tx_ff, rx_ff} <= 24'h00_0000;
			link.chip_select_low <= 1'b1;
			link.control_clock <= 1'b1;
			link.host_data_out <= 1'b1;
			link.host_data_oe <= 1'b0;
			cmd_ready_out <= 1'b1;
			done_out <= 1'b0;
			nack_out <= 1'b0;
			rd_data_out <= 8'h00;
		end else begin
			done_out <= 1'b0;
			unique case (st_ff)
				H_IDLE: begin
					if (cmd_valid_in) begin
						kind_ff <= cmd_kind_in;
						chip_ff <= cmd_chip_in;
						addr_ff <= cmd_addr_in;
						data_ff <= cmd_data_in;
						cmd_ready_out <= 1'b0;
						nack_out <= 1'b0;
						{bi_ff, step_ff, bit_ff, half_ff} <= 9'h000;
						if (cmd_kind_in == acp_pkg::CMD_TW_WRITE) begin
							tx_ff <= {cmd_chip_in, 1'b1, cmd_addr_in, cmd_data_in};
							link.chip_select_low <= 1'b0;
							link.control_clock <= 1'b0;
							link.host_data_oe <= 1'b1;
							link.host_data_out <= cmd_chip_in[1];
							st_ff <= H_BIT;
						end else begin
							st_ff <= H_START;
						end
					end
				end
				H_START: begin
					if (tick) begin
						step_ff <= step_ff + 2'h1;
						if (step_ff == 2'h0) begin
							link.host_data_oe <= 1'b0;
							link.control_clock <= 1'b1;
						end else if (step_ff == 2'h1) begin
							link.host_data_oe <= 1'b1;
							link.host_data_out <= 1'b0;
						end else begin
							// First byte loads with the clock fall
							link.control_clock <= 1'b0;
							{rd_ff, tx_ff[15:8]} <= cb;
							link.host_data_oe <= 1'b1;
							link.host_data_out <= cb[7];
							{bit_ff, half_ff, step_ff} <= 7'h00;
							st_ff <= H_BIT;
						end
					end
				end
				H_BIT: begin
					if (tick && !half_ff) begin
						link.control_clock <= 1'b1;
						half_ff <= 1'b1;
					end else if (tick) begin
						// data moves only after clock falls
						link.control_clock <= 1'b0;
						half_ff <= 1'b0;
						bit_ff <= bit_ff + 4'h1;
						tx_ff <= {tx_ff[14:0], 1'b0};
						if (kind_ff == acp_pkg::CMD_TW_WRITE) begin
							link.host_data_out <= tx_ff[14];
							if (bit_ff == 4'(acp_pkg::TW_FRAME_BITS - 1)) begin
								st_ff <= H_TW_END;
							end
						end else if (bit_ff < 4'h8) begin
							rx_ff <= {rx_ff[6:0], s2_ff};
							link.host_data_oe <= !rd_ff && bit_ff < 4'h7;
							link.host_data_out <= tx_ff[14];
						end else if ((!rd_ff && s2_ff) || rd_ff) begin
							// Refused byte or single read: stop
							nack_out <= !rd_ff;
							if (rd_ff) begin
								rd_data_out <= rx_ff;
							end
							link.host_data_oe <= 1'b1;
							link.host_data_out <= 1'b0;
							st_ff <= H_STOP;
						end else if (kind_ff == acp_pkg::CMD_RAND_READ &&
								bi_ff == 2'h1) begin
							bi_ff <= 2'h2;
							step_ff <= 2'h0;
							st_ff <= H_START;
						end else if (kind_ff == acp_pkg::CMD_TWI_WRITE &&
								bi_ff == 2'h2) begin
							link.host_data_oe <= 1'b1;
							link.host_data_out <= 1'b0;
							st_ff <= H_STOP;
						end else begin
							bi_ff <= bi_ff + 2'h1;
							bit_ff <= 4'h0;
							{rd_ff, tx_ff[15:8]} <= nb;
							link.host_data_oe <= !nb[8];
							link.host_data_out <= nb[7];
						end
					end
				end
				H_STOP: begin
					if (tick) begin
						step_ff <= step_ff + 2'h1;
						if (step_ff == 2'h0) begin
							link.control_clock <= 1'b1;
						end else begin
							link.host_data_oe <= 1'b0;
							cmd_ready_out <= 1'b1;
							done_out <= 1'b1;
							st_ff <= H_IDLE;
						end
					end
				end
				H_TW_END: begin
					// Select rises before the clock, so no 17th edge
					if (tick) begin
						step_ff <= step_ff + 2'h1;
						if (step_ff == 2'h0) begin
							link.chip_select_low <= 1'b1;
							// Let the pin float high while the clock is low
							link.host_data_oe <= 1'b0;
						end else begin
							link.control_clock <= 1'b1;
							cmd_ready_out <= 1'b1;
							done_out <= 1'b1;
							st_ff <= H_IDLE;
						end
					end
				end
			endcase
		end
	end
endmodule : acp_host
`default_nettype wire

// ---- src/acp_link_if.sv ----
// Shared control pins between host and converter
`timescale 1ns/1ps
`default_nettype none
interface acp_link_if;
	// ==========================================================
	// Pins
	logic chip_select_low;   // Frame select, host driven
	logic control_clock;     // Serial clock, host driven
	logic host_data_out;     // Host value on the data pin
	logic host_data_oe;      // Host drives the data pin
	logic dev_data_out;      // Device value on the data pin
	logic dev_data_oe;       // Device drives the data pin
	wire logic data_level;   // Resolved pin, pulled up when idle

	// Wired-and: any driver pulling low wins
	assign data_level = (~host_data_oe | host_data_out) &
	                    (~dev_data_oe | dev_data_out);

	modport device (input chip_select_low, control_clock, data_level,
	                output dev_data_out, dev_data_oe);
	modport host (output chip_select_low, control_clock, host_data_out,
	              host_data_oe, input data_level);
endinterface : acp_link_if
`default_nettype wire

// ---- src/acp_pkg.sv ----
// Shared constants and types of the ADC control port
`default_nettype none
package acp_pkg;
	// ==========================================================
	// Frame and register layout
	localparam int         TW_FRAME_BITS = 16;       // 2 chip, 1 dir, 5 addr, 8 data
	localparam int         TW_CNT_MAX    = 17;       // Edge count saturates here
	localparam logic [4:0] TWI_ID        = 5'h04;    // Fixed upper address 00100
	localparam int         NUM_REGS      = 8;        // Implemented registers
	localparam logic [5:0] LAST_REG      = 6'h07;    // Counter wraps after this
	localparam logic [5:0] RO_REG        = 6'h06;    // Test register, read only
	localparam int         TIMING_REG    = 1;        // Register holding timing bit
	localparam int         TIMING_BIT    = 0;        // Timing reset bit position
	// Register i sits in bits [8i+7:8i]
	localparam logic [63:0] REG_DEFAULTS = 64'h0000_0000_0001_01ff;

	// ==========================================================
	// Timing
	localparam int SYS_CLK_MHZ = 200;   // System clock rate
	localparam int TWI_HALF_NS = 1250;  // Half period of a 400 kHz clock
	localparam int TW_HALF_NS  = 100;   // Half period of a 5 MHz clock
	localparam int TWI_HALF = (TWI_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int TW_HALF  = (TW_HALF_NS * SYS_CLK_MHZ + 999) / 1000;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {MODE_TW, MODE_TWI, MODE_PAR} acp_mode_type;
	typedef enum logic [1:0] {
		CMD_TW_WRITE, CMD_TWI_WRITE, CMD_RAND_READ, CMD_CUR_READ
	} acp_cmd_type;
endpackage : acp_pkg
`default_nettype wire

// ---- testbench/acp_assertions.sv ----
// Checks on the pins between the host and the device
`timescale 1ns/1ps
`default_nettype none
module acp_assertions (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_in,
	// Link pins
	input wire logic chip_select_low,
	input wire logic control_clock,
	input wire logic host_data_out,
	input wire logic host_data_oe,
	input wire logic dev_data_out,
	input wire logic dev_data_oe,
	input wire logic data_level
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	// ==========================================================
	// Frame clock count, saturating so long frames still show
	logic [4:0] edges_ff;  // Rising link clocks in the frame
	logic       clk_ff;    // Link clock one cycle ago
	always_ff @(posedge sys_clk_in) begin
		clk_ff <= control_clock;
		if (reset_in || chip_select_low) begin
			edges_ff <= 5'h00;
		end else if (control_clock && !clk_ff && edges_ff != 5'h1f) begin
			edges_ff <= edges_ff + 5'h01;
		end
	end
	// ==========================================================
	// Link properties
	sequence s_drv;
		$rose(dev_data_oe);
	endsequence
	property p_len;
		$rose(chip_select_low) |-> edges_ff == 5'h10;
	endproperty
	a_len: assert property (p_len) else $error("frame length");
	property p_close;
		$rose(chip_select_low) |-> !control_clock;
	endproperty
	a_close: assert property (p_close) else $error("frame close");
	property p_tw;
		!chip_select_low && control_clock && $past(control_clock)
			|-> $stable(host_data_out);
	endproperty
	a_tw: assert property (p_tw) else $error("frame data moved");
	property p_rb;
		!chip_select_low |-> !dev_data_oe;
	endproperty
	a_rb: assert property (p_rb) else $error("frame readback");
	property p_clash;
		dev_data_oe && control_clock |-> !host_data_oe;
	endproperty
	a_clash: assert property (p_clash) else $error("pin clash");
	property p_hold;
		dev_data_oe && $past(dev_data_oe) && control_clock
			|-> $stable(dev_data_out);
	endproperty
	a_hold: assert property (p_hold) else $error("data moved");
	property p_on;
		s_drv |-> !control_clock && !$past(control_clock);
	endproperty
	a_on: assert property (p_on) else $error("drive at high");
	property p_keep;
		s_drv |-> dev_data_oe [*8];
	endproperty
	a_keep: assert property (p_keep) else $error("short drive");
endmodule : acp_assertions
`default_nettype wire

// ---- testbench/adc_control_port_tb.sv ----
// Bench joining the host and device ends of the control port
`timescale 1ns/1ps
`default_nettype none
module adc_control_port_tb;
	// ==========================================================
	// Stimulus and observed signals
	logic                  clk = 1'b0;
	logic                  rst, pd_low, bsel, psel, valid;
	logic                  ready, done, nack, tres;
	logic [1:0]            pins, chip;
	logic [4:0]            addr;
	logic [7:0]            data, rd;
	logic [63:0]           regs, exp_regs;
	logic [2:0]            ptr;       // Expected address counter
	acp_pkg::acp_cmd_type  kind;
	acp_pkg::acp_mode_type mode;
	int                    mismatches, comparisons, seed, i;
	acp_link_if link ();
	acp_device i_acp_device (.sys_clk_in(clk), .reset_in(rst), .link(link),
		.power_down_low_in(pd_low), .bus_select_in(bsel),
		.parallel_serial_select_in(psel), .device_address_pins_in(pins),
		.regs_out(regs), .timing_reset_out(tres), .mode_out(mode));
	acp_host i_acp_host (.sys_clk_in(clk), .reset_in(rst), .link(link),
		.cmd_valid_in(valid), .cmd_kind_in(kind), .cmd_chip_in(chip),
		.cmd_addr_in(addr), .cmd_data_in(data), .cmd_ready_out(ready),
		.done_out(done), .nack_out(nack), .rd_data_out(rd));
	acp_assertions i_acp_assertions (.sys_clk_in(clk), .reset_in(rst),
		.chip_select_low(link.chip_select_low),
		.control_clock(link.control_clock), .host_data_out(link.host_data_out),
		.host_data_oe(link.host_data_oe), .dev_data_out(link.dev_data_out),
		.dev_data_oe(link.dev_data_oe), .data_level(link.data_level));
	always #2.5 clk = ~clk;
	// A write lands only on a matching, writable address
	function automatic logic lands(input logic [1:0] c, input logic [4:0] a);
		return c === pins && a < 5'h08 && a != 5'h06;
	endfunction : lands
	task automatic chk(input string n, input logic [63:0] e, g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	// One command, then the model steps and compares
	task automatic run(input acp_pkg::acp_cmd_type k, input logic [1:0] c,
		input logic [4:0] a, input logic [7:0] d);
		int n;
		logic hit;
		kind = k;
		{chip, addr, data, valid} = {c, a, d, 1'b1};
		@(posedge clk);
		#1 valid = 1'b0;
		for (n = 0; done !== 1'b1 && n < 40000; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 40000) begin
			mismatches++;
			conclude();
		end
		repeat (8) @(posedge clk);
		#1 hit = c === pins && !(bsel && psel);
		if (lands(c, a) && !k[1] &&
				(k == acp_pkg::CMD_TW_WRITE ? !bsel : hit)) begin
			exp_regs[{a[2:0], 3'h0} +: 8] = d;
		end
		if (k != acp_pkg::CMD_TW_WRITE) begin
			chk("nack", {63'h0, !hit}, {63'h0, nack});
			if (hit && k != acp_pkg::CMD_CUR_READ) ptr = a[2:0];
			if (hit && k[1]) chk("read", exp_regs[{ptr, 3'h0} +: 8], rd);
			if (hit) ptr = ptr + 3'h1;
		end
		chk("regs", exp_regs, regs);
		chk("timing", {63'h0, !exp_regs[8]}, {63'h0, tres});
		chk("idle", 64'h3, {62'h0, link.chip_select_low, link.data_level});
		chk("ready", 64'h1, {63'h0, ready});
	endtask : run
	// ==========================================================
	// Main sequence
	initial begin
		{seed, mismatches, comparisons, ptr} = {32'h26c8, 64'h0, 3'h0};
		{rst, pd_low, bsel, psel, valid} = 5'b11000;
		kind = acp_pkg::CMD_TW_WRITE;
		{chip, addr, data} = 15'h0000;
		pins = 2'($random(seed));
		exp_regs = acp_pkg::REG_DEFAULTS;
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		for (i = 0; i < 4; i++) begin
			{bsel, psel} = {i == 1 || i == 2, i == 2};
			repeat (6) @(posedge clk);
			#1 chk("mode", 64'(i % 3), {62'h0, mode});
		end
		$display("mode test done");
		run(acp_pkg::CMD_TW_WRITE, pins, 5'h01, 8'h00);
		run(acp_pkg::CMD_TW_WRITE, ~pins, 5'h02, 8'h5a);
		for (i = 0; i < 16; i++) begin
			run(acp_pkg::CMD_TW_WRITE, 2'($random(seed)),
				{2'h0, 3'($random(seed))}, 8'($random(seed)));
		end
		$display("3-wire test done");
		pd_low = 1'b0;
		repeat (10) @(posedge clk);
		#1 pd_low = 1'b1;
		repeat (6) @(posedge clk);
		#1 {exp_regs, ptr} = {acp_pkg::REG_DEFAULTS, 3'h0};
		chk("power down", exp_regs, regs);
		$display("power down test done");
		run(acp_pkg::CMD_TWI_WRITE, pins, 5'h07, 8'h3c);
		{bsel, psel} = 2'b10;
		repeat (6) @(posedge clk);
		#1 run(acp_pkg::CMD_TW_WRITE, pins, 5'h02, 8'ha5);
		run(acp_pkg::CMD_CUR_READ, pins, 5'h00, 8'h00);
		run(acp_pkg::CMD_RAND_READ, pins, 5'h07, 8'h00);
		run(acp_pkg::CMD_TWI_WRITE, ~pins, 5'h01, 8'h00);
		{bsel, psel} = 2'b11;
		repeat (6) @(posedge clk);
		#1 run(acp_pkg::CMD_TWI_WRITE, pins, 5'h02, 8'h77);
		$display("two-wire test done");
		conclude();
	end
endmodule : adc_control_port_tb
`default_nettype wire
